/* logic/emacs_pkg.sv */
// Register map, field positions and constants of the MAC status block
package emacs_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	localparam logic [7:0] OFF_NETWORK_STATE   = 8'h08;
	localparam logic [7:0] OFF_TX_STATE_REG    = 8'h14;
	localparam logic [7:0] OFF_RX_DESC_POINTER = 8'h18;
	localparam logic [7:0] OFF_TX_DESC_POINTER = 8'h1C;
	localparam logic [7:0] OFF_RX_STATE_REG    = 8'h20;
	localparam logic [7:0] OFF_EVENT_REG       = 8'h24;
	localparam logic [7:0] OFF_EVENT_ENABLE    = 8'h28;
	localparam logic [7:0] OFF_EVENT_ENABLED   = 8'h30;

	// Network state fields
	localparam int unsigned NS_MDIO = 1;
	localparam int unsigned NS_IDLE = 2;

	// Transmit state fields
	localparam int unsigned TS_OWNED  = 0;
	localparam int unsigned TS_COL    = 1;
	localparam int unsigned TS_RETRY  = 2;
	localparam int unsigned TS_ACTIVE = 3;
	localparam int unsigned TS_RANOUT = 4;
	localparam int unsigned TS_COMP   = 5;
	localparam int unsigned TS_STARVE = 6;

	// Receive state fields
	localparam int unsigned RS_NOBUF = 0;
	localparam int unsigned RS_REC   = 1;
	localparam int unsigned RS_FAIL  = 2;

	// Event register fields
	localparam int unsigned EV_MGMT   = 0;
	localparam int unsigned EV_RCOMP  = 1;
	localparam int unsigned EV_RXUSED = 2;
	localparam int unsigned EV_TXUSED = 3;
	localparam int unsigned EV_TUND   = 4;
	localparam int unsigned EV_RETRY  = 5;
	localparam int unsigned EV_TXERR  = 6;
	localparam int unsigned EV_TCOMP  = 7;
	localparam int unsigned EV_ROVR   = 10;
	localparam int unsigned EV_BUSERR = 11;
	localparam int unsigned EV_PFR    = 12;
	localparam int unsigned EV_PTZ    = 13;
	localparam int unsigned EV_W      = 14;

	localparam logic [6:0]  TX_STATE_RESET = 7'h00;
	localparam logic [2:0]  RX_STATE_RESET = 3'h0;
	localparam logic [13:0] EVENT_RESET    = 14'h0000;
	localparam logic [31:0] POINTER_RESET  = 32'h00000000;

	// Descriptor ring: two words per descriptor, 1024 entries at most
	localparam int unsigned RING_ENTRIES = 1024;
	localparam int unsigned DESC_SHIFT   = 3;
	localparam int unsigned SYNC_W       = 3;
endpackage

/* logic/emacs_queue_pointer.sv */
// Descriptor queue pointer with advance, wrap, frame mark and rewind
`timescale 1ns/10ps
module emacs_queue_pointer
	import emacs_pkg::*;
#(
	parameter int unsigned ENTRIES = RING_ENTRIES
) (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        load,
	input  wire logic [31:0] loadValue,
	input  wire logic        advance,
	input  wire logic        wrapBit,
	input  wire logic        mark,
	input  wire logic        rewind,
	output logic      [31:0] current,
	output logic      [31:0] marked
);
	localparam int unsigned CW = $clog2(ENTRIES);

	logic [31:0]   start_q;
	logic [CW-1:0] count_q;
	logic [CW-1:0] count_d;
	logic [CW-1:0] mark_q;
	logic [CW-1:0] mark_d;
	wire           lastEntry = (count_q == CW'(ENTRIES - 1));
	wire  [CW-1:0] stepped   = (wrapBit || lastEntry) ? '0 : count_q + 1'b1;

	assign count_d = load ? '0 :
		rewind ? mark_q :
		advance ? stepped : count_q;
	assign mark_d = load ? '0 : mark ? count_d : mark_q;

	// Only the low bits move, so the ring never leaves its window
	function automatic logic [31:0] place(input logic [CW-1:0] idx);
		logic [CW+DESC_SHIFT-1:0] low;
		low = start_q[CW+DESC_SHIFT-1:0] + {idx, DESC_SHIFT'(0)};
		place = {start_q[31:CW+DESC_SHIFT], low};
	endfunction

	assign current = place(count_q);
	assign marked  = place(mark_q);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			start_q <= POINTER_RESET;
			count_q <= '0;
			mark_q  <= '0;
		end else begin
			if (load) begin
				start_q <= loadValue;
			end
			count_q <= count_d;
			mark_q  <= mark_d;
		end
	end

	pointer_wrap_a: assert property (@(posedge clock) disable iff (!resetn)
		(advance && !load && !rewind && (wrapBit || lastEntry))
		|=> count_q == '0)
	else $error("queue pointer did not return to start");

	pointer_load_a: assert property (@(posedge clock) disable iff (!resetn)
		load |=> current == $past(loadValue))
	else $error("queue pointer did not load written start");
endmodule // emacs_queue_pointer

/* logic/emacs_status.sv */
// Status registers and descriptor queue pointers of the Ethernet MAC
`timescale 1ns/10ps
module emacs_status
	import emacs_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        resetn,
	// Avalon-MM slave
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// Pins
	input  wire logic        mdioIn,
	input  wire logic        collision,
	input  wire logic        txClk,
	// Management shifter
	input  wire logic        mgmtBusy,
	input  wire logic        mgmtDone,
	// Transmit engine and DMA
	input  wire logic        txActive,
	input  wire logic        txOwnedDescSeen,
	input  wire logic        txRetriesExhausted,
	input  wire logic        txBuffersRanOut,
	input  wire logic        txFrameDone,
	input  wire logic        txStarved,
	input  wire logic        txBufferUsed,
	input  wire logic        txWrapBit,
	// Receive DMA
	input  wire logic        rxNoBuffer,
	input  wire logic        rxOwnedDescSeen,
	input  wire logic        rxFrameStored,
	input  wire logic        rxStoreFail,
	input  wire logic        rxBufferUsed,
	input  wire logic        rxWrapBit,
	input  wire logic        busError,
	// Outputs to the DMA, the link and the interrupt logic
	output logic      [31:0] rxDescAddr,
	output logic      [31:0] txDescAddr,
	output logic             txErrorOut,
	output logic             txForceBadCrc,
	output logic      [13:0] eventEnabled
);
	// Bus handshake: one wait cycle, then the request is taken
	logic        ack_q;
	logic [31:0] readdata_q;
	wire         busReq   = read || write;
	wire         takeNow  = busReq && ack_q;
	wire         takeWr   = takeNow && write;
	wire         takeRd   = takeNow && read;
	wire  [31:0] wmask    = {{8{byteenable[3]}}, {8{byteenable[2]}},
		{8{byteenable[1]}}, {8{byteenable[0]}}};
	wire  [31:0] wdata    = writedata & wmask;

	assign waitrequest = busReq && !ack_q;
	assign readdata    = readdata_q;

	function automatic logic hit(input logic [7:0] off);
		hit = (address[7:2] == off[7:2]);
	endfunction

	wire selNet   = hit(OFF_NETWORK_STATE);
	wire selTx    = hit(OFF_TX_STATE_REG);
	wire selRxPtr = hit(OFF_RX_DESC_POINTER);
	wire selTxPtr = hit(OFF_TX_DESC_POINTER);
	wire selRx    = hit(OFF_RX_STATE_REG);
	wire selEv    = hit(OFF_EVENT_REG);
	wire selEn    = hit(OFF_EVENT_ENABLE);
	wire selEnRd  = hit(OFF_EVENT_ENABLED);

	// Pin synchronisers: only the last stage is read
	logic [SYNC_W-1:0] pinMeta_q;
	logic [SYNC_W-1:0] pinSync_q;
	logic              txClkLast_q;
	wire  [SYNC_W-1:0] pinRaw = {txClk, collision, mdioIn};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : gSync
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					pinMeta_q[gi] <= 1'b0;
					pinSync_q[gi] <= 1'b0;
				end else begin
					pinMeta_q[gi] <= pinRaw[gi];
					pinSync_q[gi] <= pinMeta_q[gi];
				end
			end
		end
	endgenerate

	wire mdioLive  = pinSync_q[0];
	wire colLive   = pinSync_q[1];
	wire txClkRise = pinSync_q[2] && !txClkLast_q;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			txClkLast_q <= 1'b0;
		end else begin
			txClkLast_q <= pinSync_q[2];
		end
	end

	// Collision counts only while a frame is on the wire
	wire colEvent = txClkRise && colLive && txActive;

	// Transmit pointer ignores writes while the transmitter runs
	wire txPtrLoad = takeWr && selTxPtr && !txActive;
	wire rxPtrLoad = takeWr && selRxPtr;

	// Transmit state: set events, write-one clears; a set beats a clear
	logic [6:0] txState_q;
	logic [6:0] txState_d;
	logic [6:0] txSet;
	logic [6:0] txClr;

	assign txSet = {txStarved, txFrameDone, txBuffersRanOut, 1'b0,
		txRetriesExhausted, colEvent, txOwnedDescSeen};
	assign txClr = (takeWr && selTx) ? wdata[6:0] : 7'h00;
	assign txState_d = (txState_q & ~txClr) | txSet;

	// Receive state
	logic [2:0] rxState_q;
	logic [2:0] rxState_d;
	logic [2:0] rxSet;
	logic [2:0] rxClr;

	assign rxSet = {rxStoreFail, rxFrameStored, rxNoBuffer};
	assign rxClr = (takeWr && selRx) ? wdata[2:0] : 3'h0;
	assign rxState_d = (rxState_q & ~rxClr) | rxSet;

	// Event register: latched, cleared by the read that returns it
	logic [EV_W-1:0] event_q;
	logic [EV_W-1:0] event_d;
	logic [EV_W-1:0] evSet;
	logic [EV_W-1:0] enable_q;

	always_comb begin
		evSet            = '0;
		evSet[EV_MGMT]   = mgmtDone;
		evSet[EV_RCOMP]  = rxFrameStored;
		evSet[EV_RXUSED] = rxOwnedDescSeen;
		evSet[EV_TXUSED] = txOwnedDescSeen;
		evSet[EV_TUND]   = txStarved || txPtrLoad;
		evSet[EV_RETRY]  = txRetriesExhausted;
		evSet[EV_TXERR]  = txBuffersRanOut;
		evSet[EV_TCOMP]  = txFrameDone;
		evSet[EV_ROVR]   = rxStoreFail;
		evSet[EV_BUSERR] = busError;
	end

	// Only bits that the read returned are cleared, so an event landing
	// in the wait cycle is kept for the next read instead of being lost
	wire [EV_W-1:0] evShown = (takeRd && selEv) ? readdata_q[EV_W-1:0] : '0;

	assign event_d = (event_q & ~evShown) | evSet;

	// Enable register is write-one only; it gates nothing here but is
	// handed to the interrupt logic beside this block
	wire [EV_W-1:0] enSet = (takeWr && selEn) ? wdata[EV_W-1:0] : '0;

	assign eventEnabled = enable_q;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			txState_q <= TX_STATE_RESET;
			rxState_q <= RX_STATE_RESET;
			event_q   <= EVENT_RESET;
			enable_q  <= EVENT_RESET;
		end else begin
			txState_q <= txState_d;
			rxState_q <= rxState_d;
			event_q   <= event_d;
			enable_q  <= enable_q | enSet;
		end
	end

	// Link-side error signalling
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			txErrorOut    <= 1'b0;
			txForceBadCrc <= 1'b0;
		end else begin
			txErrorOut    <= txBuffersRanOut;
			txForceBadCrc <= txBuffersRanOut || txStarved;
		end
	end

	// Queue pointers: each advance moves one two-word descriptor
	logic [31:0] rxPtrNow;
	logic [31:0] txPtrNow;
	logic [31:0] txPtrFrame;

	// A failed store rewinds to the first buffer of the frame
	emacs_queue_pointer #(
		.ENTRIES(RING_ENTRIES)
	) uRxPointer (
		.clock    (clock),
		.resetn   (resetn),
		.load     (rxPtrLoad),
		.loadValue(wdata),
		.advance  (rxBufferUsed),
		.wrapBit  (rxWrapBit),
		.mark     (rxFrameStored),
		.rewind   (rxStoreFail),
		.current  (rxPtrNow),
		.marked   ()
	);

	emacs_queue_pointer #(
		.ENTRIES(RING_ENTRIES)
	) uTxPointer (
		.clock    (clock),
		.resetn   (resetn),
		.load     (txPtrLoad),
		.loadValue(wdata),
		.advance  (txBufferUsed),
		.wrapBit  (txWrapBit),
		.mark     (txFrameDone),
		.rewind   (1'b0),
		.current  (txPtrNow),
		.marked   (txPtrFrame)
	);

	assign rxDescAddr = rxPtrNow;
	assign txDescAddr = txPtrNow;

	// Read mux: reserved bits and unmapped words read zero
	logic [31:0] rdMux;

	always_comb begin
		rdMux = 32'h00000000;
		if (selNet) begin
			rdMux[NS_MDIO] = mdioLive;
			rdMux[NS_IDLE] = !mgmtBusy;
		end else if (selTx) begin
			rdMux[6:0]       = txState_q;
			rdMux[TS_ACTIVE] = txActive;
		end else if (selRxPtr) begin
			rdMux = rxPtrNow;
		end else if (selTxPtr) begin
			rdMux = txPtrFrame;
		end else if (selRx) begin
			rdMux[2:0] = rxState_q;
		end else if (selEv) begin
			rdMux[EV_W-1:0] = event_q;
		end else if (selEnRd) begin
			rdMux[EV_W-1:0] = enable_q;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ack_q      <= 1'b0;
			readdata_q <= 32'h00000000;
		end else begin
			ack_q      <= busReq && !ack_q;
			readdata_q <= rdMux;
		end
	end

	// Checks

	idle_bit_a: assert property (@(posedge clock) disable iff (!resetn)
		(busReq && !ack_q && read && selNet)
		|=> readdata[NS_IDLE] == !$past(mgmtBusy))
	else $error("idle bit does not follow management busy");

	mdio_live_a: assert property (@(posedge clock) disable iff (!resetn)
		(busReq && !ack_q && read && selNet)
		|=> readdata[NS_MDIO] == $past(pinSync_q[0]))
	else $error("mdio bit not the synchronised pin level");

	clear_one_a: assert property (@(posedge clock) disable iff (!resetn)
		(takeWr && selTx && !writedata[TS_COMP] && txState_q[TS_COMP])
		|=> txState_q[TS_COMP])
	else $error("writing zero cleared a transmit status bit");

	no_write_set_a: assert property (@(posedge clock) disable iff (!resetn)
		(takeWr && selRx && !rxState_q[RS_REC] && !rxFrameStored)
		|=> !rxState_q[RS_REC])
	else $error("a register write set a receive status bit");

	owned_desc_a: assert property (@(posedge clock) disable iff (!resetn)
		txOwnedDescSeen |=> txState_q[TS_OWNED] && event_q[EV_TXUSED])
	else $error("owned descriptor fetch not flagged");

	collision_set_a: assert property (@(posedge clock) disable iff (!resetn)
		(txClkRise && colLive && txActive) |=> txState_q[TS_COL])
	else $error("collision not flagged");

	active_live_a: assert property (@(posedge clock) disable iff (!resetn)
		(busReq && !ack_q && read && selTx)
		|=> readdata[TS_ACTIVE] == $past(txActive))
	else $error("transmit active bit not live");

	ran_out_a: assert property (@(posedge clock) disable iff (!resetn)
		txBuffersRanOut
		|=> txErrorOut && txForceBadCrc && txState_q[TS_RANOUT])
	else $error("buffers ran out without error signalling");

	frame_done_a: assert property (@(posedge clock) disable iff (!resetn)
		txFrameDone |=> txState_q[TS_COMP] && event_q[EV_TCOMP])
	else $error("finished frame not flagged");

	starved_a: assert property (@(posedge clock) disable iff (!resetn)
		txStarved |=> txForceBadCrc && txState_q[TS_STARVE])
	else $error("starved transmit not flagged");

	tx_ptr_lock_a: assert property (@(posedge clock) disable iff (!resetn)
		(takeWr && selTxPtr && txActive && !txBufferUsed && !txFrameDone)
		|=> $stable(txPtrFrame) && $stable(txPtrNow))
	else $error("transmit pointer written while active");

	no_buffer_a: assert property (@(posedge clock) disable iff (!resetn)
		rxNoBuffer |=> rxState_q[RS_NOBUF])
	else $error("failed receive fetch not flagged");

	stored_fail_a: assert property (@(posedge clock) disable iff (!resetn)
		(rxFrameStored |=> rxState_q[RS_REC])
		and (rxStoreFail |=> rxState_q[RS_FAIL]))
	else $error("receive frame outcome not flagged");

	read_clear_a: assert property (@(posedge clock) disable iff (!resetn)
		(takeRd && selEv && readdata[EV_MGMT] && !mgmtDone)
		|=> !event_q[EV_MGMT])
	else $error("event register not cleared by read");

	enable_set_a: assert property (@(posedge clock) disable iff (!resetn)
		(takeWr && selEn && writedata[EV_TCOMP] && byteenable[0])
		|=> eventEnabled[EV_TCOMP])
	else $error("enable write did not take");

	bus_answer_a: assert property (@(posedge clock) disable iff (!resetn)
		(busReq && !ack_q) |=> !waitrequest || !busReq)
	else $error("bus request waited more than one cycle");
endmodule // emacs_status

/* tb/emacs_phy_model.sv */
// Link-side partner: transmit clock, collision and management data pins
`timescale 1ns/10ps
module emacs_phy_model (
	input  wire logic run,
	input  wire logic collide,
	input  wire logic mdioDrive,
	input  wire logic mdioLevel,
	output logic      txClk,
	output logic      collision,
	output logic      mdioIn
);
	// Clock stands still between frames, 80 ns period while running
	initial begin
		txClk = 1'b0;
		forever begin
			#40;
			txClk = run ? ~txClk : 1'b0;
		end
	end
	assign collision = collide & run;
	// A released data line floats up to its pull-up
	assign mdioIn = mdioDrive ? mdioLevel : 1'b1;
endmodule // emacs_phy_model

/* tb/tb_emac_status_and_queue_pointers.sv */
// Self-checking bench for the MAC status and queue pointer block
`timescale 1ns/10ps
module tb_emac_status_and_queue_pointers
	import emacs_pkg::*;
;
	logic        clock;
	logic        resetn;
	logic [7:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        txClk;
	logic        collision;
	logic        mdioIn;
	logic        mgmtBusy;
	logic        txActive;
	logic        txWrapBit;
	logic        rxWrapBit;
	logic        run;
	logic        collide;
	logic        mdioDrive;
	logic        mdioLevel;
	logic [12:0] ev;
	logic [31:0] rxDescAddr;
	logic [31:0] txDescAddr;
	logic        txErrorOut;
	logic        txForceBadCrc;
	logic [13:0] eventEnabled;
	logic [31:0] errSeen;
	logic [31:0] q;
	logic [31:0] m;
	logic [7:0]  a;
	int          failures;
	int          total_checks;
	int          cycles;
	int unsigned bitPos[8] = '{TS_OWNED, TS_RETRY, TS_RANOUT, TS_COMP,
		TS_STARVE, RS_NOBUF, RS_REC, RS_FAIL};

	emacs_phy_model phy (.run(run), .collide(collide), .mdioDrive(mdioDrive),
		.mdioLevel(mdioLevel), .txClk(txClk), .collision(collision),
		.mdioIn(mdioIn));

	emacs_status dut (.clock(clock), .resetn(resetn), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
		.mdioIn(mdioIn), .collision(collision), .txClk(txClk),
		.mgmtBusy(mgmtBusy), .mgmtDone(ev[10]), .txActive(txActive),
		.txOwnedDescSeen(ev[0]), .txRetriesExhausted(ev[1]),
		.txBuffersRanOut(ev[2]), .txFrameDone(ev[3]), .txStarved(ev[4]),
		.txBufferUsed(ev[8]), .txWrapBit(txWrapBit), .rxNoBuffer(ev[5]),
		.rxOwnedDescSeen(ev[11]), .rxFrameStored(ev[6]),
		.rxStoreFail(ev[7]), .rxBufferUsed(ev[9]), .rxWrapBit(rxWrapBit),
		.busError(ev[12]), .rxDescAddr(rxDescAddr), .txDescAddr(txDescAddr),
		.txErrorOut(txErrorOut), .txForceBadCrc(txForceBadCrc),
		.eventEnabled(eventEnabled));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic close_out();
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	// One Avalon transfer; the request stands until waitrequest is low
	task automatic bus(input logic wr, input logic [7:0] ad,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clock);
		address <= ad;
		writedata <= d;
		write <= wr;
		read <= ~wr;
		// Sampled right after the edge: the values the slave saw there
		@(posedge clock);
		while (waitrequest !== 1'b0)
			@(posedge clock);
		r = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] ad, input logic [31:0] want);
		bus(1'b0, ad, 32'h0, q);
		chk(q, want);
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		bus(1'b1, ad, d, q);
	endtask

	task automatic pulse(input int i);
		@(posedge clock);
		ev[i] <= 1'b1;
		@(posedge clock);
		ev[i] <= 1'b0;
		@(posedge clock);
		errSeen = {30'h0, txErrorOut, txForceBadCrc};
	endtask

	// Hang guard: the whole sequence needs well under 10000 cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			close_out();
		end
	end

	initial begin
		{resetn, read, write, mgmtBusy, txActive} = 5'h0;
		{txWrapBit, rxWrapBit, run, collide, mdioDrive, mdioLevel} = 6'h0;
		address = 8'h00;
		writedata = 32'h0;
		ev = 13'h0000;
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		rd(OFF_TX_STATE_REG, 32'h0);
		rd(OFF_RX_STATE_REG, 32'h0);
		rd(OFF_EVENT_REG, 32'h0);
		rd(OFF_NETWORK_STATE, 32'h6);
		chk(rxDescAddr | txDescAddr, 32'h0);
		@(posedge clock);
		mgmtBusy <= 1'b1;
		mdioDrive <= 1'b1;
		repeat (4) @(posedge clock);
		rd(OFF_NETWORK_STATE, 32'h0);
		mgmtBusy <= 1'b0;
		pulse(10);
		rd(OFF_NETWORK_STATE, 32'h4);
		rd(OFF_EVENT_REG, 32'h1 << EV_MGMT);
		rd(OFF_EVENT_REG, 32'h0);
		for (int i = 0; i < 8; i++) begin
			m = 32'h1 << bitPos[i];
			a = (i < 5) ? OFF_TX_STATE_REG : OFF_RX_STATE_REG;
			pulse(i);
			chk(errSeen, {30'h0, i == 2, i == 2 || i == 4});
			rd(a, m);
			wr(a, ~m);
			rd(a, m);
			wr(a, m);
			rd(a, 32'h0);
		end
		pulse(5);
		rd(OFF_RX_STATE_REG, 32'h1);
		@(posedge clock);
		txActive <= 1'b1;
		run <= 1'b1;
		collide <= 1'b1;
		repeat (40) @(posedge clock);
		rd(OFF_TX_STATE_REG, 32'hA);
		wr(OFF_TX_DESC_POINTER, 32'h8000);
		txActive <= 1'b0;
		run <= 1'b0;
		collide <= 1'b0;
		wr(OFF_TX_STATE_REG, 32'hFF);
		rd(OFF_TX_STATE_REG, 32'h0);
		rd(OFF_TX_DESC_POINTER, 32'h0);
		// Each advance steps the receive pointer by one eight-byte descriptor
		wr(OFF_RX_DESC_POINTER, 32'h2000);
		repeat (3) pulse(9);
		rd(OFF_RX_DESC_POINTER, 32'h2018);
		chk(rxDescAddr, 32'h2018);
		// A failed store rewinds the live pointer to the mark set by the stored frame
		pulse(6);
		repeat (2) pulse(9);
		pulse(7);
		rd(OFF_RX_DESC_POINTER, 32'h2018);
		rxWrapBit <= 1'b1;
		pulse(9);
		rxWrapBit <= 1'b0;
		rd(OFF_RX_DESC_POINTER, 32'h2000);
		bus(1'b0, OFF_EVENT_REG, 32'h0, q);
		wr(OFF_TX_DESC_POINTER, 32'h4000);
		rd(OFF_EVENT_REG, 32'h1 << EV_TUND);
		pulse(11);
		pulse(12);
		rd(OFF_EVENT_REG, 32'h804);
		repeat (2) pulse(8);
		chk(txDescAddr, 32'h4010);
		rd(OFF_TX_DESC_POINTER, 32'h4000);
		pulse(3);
		rd(OFF_TX_DESC_POINTER, 32'h4010);
		repeat (1022) pulse(8);
		pulse(3);
		rd(OFF_TX_DESC_POINTER, 32'h4000);
		wr(OFF_EVENT_ENABLE, 32'h81);
		wr(OFF_EVENT_ENABLE, 32'h800);
		@(negedge clock);
		chk({18'h0, eventEnabled}, 32'h881);
		rd(OFF_EVENT_ENABLED, 32'h881);
		rd(8'h3C, 32'h0);
		close_out();
	end
endmodule // tb_emac_status_and_queue_pointers
